// ### src/wwdg_pkg.sv
// package for the window watchdog and its host end
// assumes one 20 MHz clock (hclk) shared by both ends
`default_nettype none
package wwdg_pkg;
    localparam int unsigned CLK_HZ = 20000000;
    // stage intervals in clock cycles
    localparam int unsigned MIN_WIN_CYC = 200;
    localparam int unsigned MAX_WIN_CYC = 1000;
    // supervisor times in microseconds
    localparam int unsigned POR_HOLD_US = 250000;
    localparam int unsigned DEBOUNCE_US = 10000;
    localparam int unsigned ACT_TMO_US = 1200000;
    localparam int unsigned POR_HOLD_CYC =
        (POR_HOLD_US / 1000) * (CLK_HZ / 1000);
    localparam int unsigned DEBOUNCE_CYC =
        (DEBOUNCE_US / 1000) * (CLK_HZ / 1000);
    localparam int unsigned ACT_TMO_CYC =
        (ACT_TMO_US / 1000) * (CLK_HZ / 1000);
    localparam int CNT_W = 32;
    // host register map (byte addresses)
    localparam logic [31:0] HOST_CTRL_ADDR = 32'h0000_0000;
    localparam logic [31:0] HOST_STAT_ADDR = 32'h0000_0004;
    localparam int CTRL_KICK_BIT = 0;
    localparam int CTRL_ARM_BIT = 1;
    localparam int STAT_IRQN_BIT = 0;
    localparam int STAT_KILLN_BIT = 1;
    localparam int STAT_RSTN_BIT = 2;
    localparam int STAT_BUSY_BIT = 3;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage : wwdg_pkg
`default_nettype wire

// ### src/wwdg_if.sv
// interface joining the watchdog device and the host end
// assumes both ends share hclk
`default_nettype none
interface wwdg_if;
    logic kick_sel_n;
    logic kick_wr_n;
    logic arm_sel_a_n;
    logic arm_sel_b_n;
    logic guard_fault_irq_n;
    logic drive_kill_n;
    logic sys_reset;
    logic sys_reset_n;
    logic activity_pulse_in;
    modport device (
        input kick_sel_n, kick_wr_n, arm_sel_a_n, arm_sel_b_n,
        activity_pulse_in,
        output guard_fault_irq_n, drive_kill_n, sys_reset, sys_reset_n
    );
    modport host (
        output kick_sel_n, kick_wr_n, arm_sel_a_n, arm_sel_b_n,
        activity_pulse_in,
        input guard_fault_irq_n, drive_kill_n, sys_reset, sys_reset_n
    );
endinterface : wwdg_if
`default_nettype wire

// ### src/wwdg_device.sv
// window watchdog with reset supervisor, device end
// assumes link inputs are asynchronous; power pins arrive as plain inputs
//
// Chosen here: the placing of the registers and register access over AHB-Lite.
`default_nettype none
module wwdg_device
    import wwdg_pkg::*;
#(
    parameter int unsigned POR_HOLD = POR_HOLD_CYC,
    parameter int unsigned DEBOUNCE = DEBOUNCE_CYC,
    parameter int unsigned ACT_TMO = ACT_TMO_CYC
) (
    // clock and power-on reset
    input wire logic hclk,
    input wire logic hresetn,
    // supply monitor and user pins
    input wire logic supply_good,
    input wire logic manual_reset_button_n,
    input wire logic activity_enable,
    // link to the host
    wwdg_if.device lnk
);
    typedef struct packed {
        logic [1:0] kick_sync;
        logic [1:0] arm_sync;
        logic [1:0] pb_sync;
        logic [1:0] act_sync;
        logic [1:0] sup_sync;
        logic [1:0] aen_sync;
        logic kick_strobe;
        logic act_prev;
        logic min_window_active;
        logic max_window_pending;
        logic relay_arm_flag;
        logic [CNT_W-1:0] min_cnt;
        logic [CNT_W-1:0] max_cnt;
        logic [CNT_W-1:0] hold_cnt;
        logic [CNT_W-1:0] pb_cnt;
        logic [CNT_W-1:0] act_cnt;
        logic irq_n;
        logic kill_n;
        logic rst;
        logic rst_n;
    } wwdg_dev_t;

    wwdg_dev_t st;
    wwdg_dev_t next_st;

    // =====================================================
    // watchdog and supervisor next state
    always_comb begin
        logic kick_now;
        logic kick_fall;
        logic min_rise;
        logic min_clear;
        logic early;
        logic trip;
        logic act_pulse;
        next_st = st;
        kick_now = 1'b0;
        kick_fall = 1'b0;
        min_rise = 1'b0;
        min_clear = 1'b0;
        early = 1'b0;
        trip = 1'b0;
        act_pulse = 1'b0;
        next_st.kick_sync = {st.kick_sync[0],
            ~lnk.kick_sel_n & ~lnk.kick_wr_n};
        next_st.arm_sync = {st.arm_sync[0],
            ~lnk.arm_sel_a_n & ~lnk.arm_sel_b_n};
        next_st.pb_sync = {st.pb_sync[0], manual_reset_button_n};
        next_st.act_sync = {st.act_sync[0], lnk.activity_pulse_in};
        next_st.sup_sync = {st.sup_sync[0], supply_good};
        next_st.aen_sync = {st.aen_sync[0], activity_enable};
        kick_now = st.kick_sync[1];
        next_st.kick_strobe = kick_now;
        kick_fall = st.kick_strobe & ~kick_now;
        // armed fault holds stage one cleared
        min_clear = st.relay_arm_flag & ~st.max_window_pending;
        early = kick_fall & st.min_window_active;
        if (min_clear) begin
            next_st.min_window_active = 1'b0;
            next_st.min_cnt = '0;
        end else if (kick_fall) begin
            next_st.min_window_active = 1'b1;
            next_st.min_cnt = CNT_W'(MIN_WIN_CYC - 1);
            min_rise = ~st.min_window_active;
        end else if (st.min_window_active) begin
            if (st.min_cnt == '0)
                next_st.min_window_active = 1'b0;
            else
                next_st.min_cnt = st.min_cnt - CNT_W'(1);
        end
        if (early) begin
            next_st.max_window_pending = 1'b0;
            next_st.max_cnt = '0;
        end else if (min_rise) begin
            next_st.max_window_pending = 1'b1;
            next_st.max_cnt = CNT_W'(MAX_WIN_CYC - 1);
        end else if (st.max_window_pending) begin
            if (st.max_cnt == '0)
                next_st.max_window_pending = 1'b0;
            else
                next_st.max_cnt = st.max_cnt - CNT_W'(1);
        end
        // unarmed: irq follows stage two so a good kick recovers
        next_st.irq_n = next_st.max_window_pending;
        next_st.kill_n = next_st.max_window_pending;
        if (st.arm_sync[1])
            next_st.relay_arm_flag = 1'b1;
        // supervisor: button debounce, activity timeout, hold time
        if (!st.pb_sync[1]) begin
            if (st.pb_cnt < CNT_W'(DEBOUNCE))
                next_st.pb_cnt = st.pb_cnt + CNT_W'(1);
        end else begin
            next_st.pb_cnt = '0;
        end
        act_pulse = st.act_sync[1] & ~st.act_prev;
        next_st.act_prev = st.act_sync[1];
        if (act_pulse || !st.aen_sync[1])
            next_st.act_cnt = '0;
        else if (st.act_cnt < CNT_W'(ACT_TMO))
            next_st.act_cnt = st.act_cnt + CNT_W'(1);
        trip = ~st.sup_sync[1]
            | (st.pb_cnt >= CNT_W'(DEBOUNCE))
            | (st.act_cnt >= CNT_W'(ACT_TMO));
        if (trip) begin
            next_st.rst = 1'b1;
            next_st.hold_cnt = CNT_W'(POR_HOLD);
            if (st.act_cnt >= CNT_W'(ACT_TMO))
                next_st.act_cnt = '0;
        end else if (st.hold_cnt != '0) begin
            next_st.hold_cnt = st.hold_cnt - CNT_W'(1);
        end else begin
            next_st.rst = 1'b0;
        end
        // own flop for the low copy keeps both pins glitch free
        next_st.rst_n = ~next_st.rst;
    end

    // =====================================================
    // state register; power-on reset clears everything but the button sync, irq, kill, reset and hold count
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= '0;
            st.pb_sync <= 2'h3;
            st.sup_sync <= 2'h0;
            st.irq_n <= 1'b1;
            st.kill_n <= 1'b1;
            st.rst <= 1'b1;
            st.hold_cnt <= CNT_W'(POR_HOLD);
        end else begin
            st <= next_st;
        end
    end

    assign lnk.guard_fault_irq_n = st.irq_n;
    assign lnk.drive_kill_n = st.kill_n;
    assign lnk.sys_reset = st.rst;
    assign lnk.sys_reset_n = st.rst_n;
endmodule : wwdg_device
`default_nettype wire

// ### src/wwdg_host.sv
// host end: AHB-Lite registers turn software orders into link pulses
// assumes one AHB-Lite master on hclk; link outputs are registered
`default_nettype none
module wwdg_host
    import wwdg_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // activity source for the secondary timeout
    input wire logic activity_tick,
    // link to the device
    wwdg_if.host lnk
);
    localparam logic [3:0] PULSE_LEN = 4'h8;
    typedef struct packed {
        logic wr_pend;
        logic [31:0] addr;
        logic [31:0] rdata;
        logic [3:0] kick_cnt;
        logic [3:0] arm_cnt;
        logic kick_n;
        logic arm_n;
        logic act;
        logic [2:0] in_sync0;
        logic [2:0] in_sync1;
    } wwdg_host_t;

    wwdg_host_t st;
    wwdg_host_t next_st;

    // =====================================================
    // bus decode and pulse generation
    always_comb begin
        logic take;
        take = hsel & (htrans == HTRANS_NONSEQ);
        next_st = st;
        next_st.wr_pend = take & hwrite;
        if (take)
            next_st.addr = haddr;
        if (st.wr_pend && st.addr == HOST_CTRL_ADDR) begin
            if (hwdata[CTRL_KICK_BIT])
                next_st.kick_cnt = PULSE_LEN;
            if (hwdata[CTRL_ARM_BIT])
                next_st.arm_cnt = PULSE_LEN;
        end else begin
            if (st.kick_cnt != 4'h0)
                next_st.kick_cnt = st.kick_cnt - 4'h1;
            if (st.arm_cnt != 4'h0)
                next_st.arm_cnt = st.arm_cnt - 4'h1;
        end
        // one write per program cycle makes one strobe
        next_st.kick_n = (next_st.kick_cnt == 4'h0);
        next_st.arm_n = (next_st.arm_cnt == 4'h0);
        next_st.act = activity_tick;
        next_st.in_sync0 = {lnk.sys_reset_n, lnk.drive_kill_n,
            lnk.guard_fault_irq_n};
        next_st.in_sync1 = st.in_sync0;
        next_st.rdata = 32'h0000_0000;
        if (take && !hwrite && haddr == HOST_STAT_ADDR) begin
            // fault irq low is read by firmware for code 4.2
            next_st.rdata[STAT_IRQN_BIT] = st.in_sync1[0];
            next_st.rdata[STAT_KILLN_BIT] = st.in_sync1[1];
            next_st.rdata[STAT_RSTN_BIT] = st.in_sync1[2];
            next_st.rdata[STAT_BUSY_BIT] = ~st.kick_n | ~st.arm_n;
        end else if (take && !hwrite && haddr == HOST_CTRL_ADDR) begin
            next_st.rdata[CTRL_KICK_BIT] = ~st.kick_n;
            next_st.rdata[CTRL_ARM_BIT] = ~st.arm_n;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= '0;
            st.kick_n <= 1'b1;
            st.arm_n <= 1'b1;
            // match the device pins during reset: irq and kill high,
            // supervisor reset active, so no false ready is read
            st.in_sync0 <= 3'h3;
            st.in_sync1 <= 3'h3;
        end else begin
            st <= next_st;
        end
    end

    assign hrdata = st.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign lnk.kick_sel_n = st.kick_n;
    assign lnk.kick_wr_n = st.kick_n;
    assign lnk.arm_sel_a_n = st.arm_n;
    assign lnk.arm_sel_b_n = st.arm_n;
    assign lnk.activity_pulse_in = st.act;
endmodule : wwdg_host
`default_nettype wire

// ### tb/wwdg_properties.sv
// checker for the watchdog link between device and host ends
// assumes it is instantiated beside the interface, clocked by hclk
`default_nettype none
module wwdg_properties
    import wwdg_pkg::*;
#(
    parameter int unsigned POR_HOLD = 20
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // host orders
    input wire logic kick_sel_n,
    input wire logic kick_wr_n,
    input wire logic arm_sel_a_n,
    input wire logic arm_sel_b_n,
    // device answers
    input wire logic guard_fault_irq_n,
    input wire logic drive_kill_n,
    input wire logic sys_reset,
    input wire logic sys_reset_n
);
    // ========================================
    // helper state
    logic kick_on;
    logic seen_kick;
    logic armed;
    logic [1:0] arm_dly;
    logic [15:0] since_kick;
    logic [15:0] since_rst;
    assign kick_on = !kick_sel_n && !kick_wr_n;
    // arm is mirrored two cycles late, matching the link synchroniser
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            seen_kick <= 1'b0;
            armed <= 1'b0;
            arm_dly <= 2'h0;
            since_kick <= 16'h0;
            since_rst <= 16'h0;
        end else begin
            arm_dly <= {arm_dly[0], !arm_sel_a_n && !arm_sel_b_n};
            if (arm_dly[1]) armed <= 1'b1;
            if (kick_on) seen_kick <= 1'b1;
            if (kick_on) since_kick <= 16'h0;
            else if (since_kick != 16'hFFFF) since_kick <= since_kick + 16'h1;
            if (since_rst != 16'hFFFF) since_rst <= since_rst + 16'h1;
        end
    end
    // ========================================
    // properties
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_kill_follows;
        drive_kill_n == guard_fault_irq_n;
    endproperty
    a_kill_follows: assert property (p_kill_follows)
        else $error("kill output differs from fault irq");
    property p_rst_pair;
        sys_reset == !sys_reset_n;
    endproperty
    a_rst_pair: assert property (p_rst_pair)
        else $error("reset polarities disagree");
    property p_por_hold;
        since_rst < POR_HOLD |-> sys_reset && !sys_reset_n;
    endproperty
    a_por_hold: assert property (p_por_hold)
        else $error("reset released too early");
    property p_late;
        since_kick > 16'h04CE |-> !guard_fault_irq_n;
    endproperty
    a_late: assert property (p_late)
        else $error("missed kick left irq high");
    property p_rise_kick;
        $rose(guard_fault_irq_n) |-> seen_kick && since_kick < 16'h0010;
    endproperty
    a_rise_kick: assert property (p_rise_kick)
        else $error("irq rose without a kick");
    property p_rise_unarmed;
        $rose(guard_fault_irq_n) |-> !armed;
    endproperty
    a_rise_unarmed: assert property (p_rise_unarmed)
        else $error("irq rose while armed");
    property p_latch;
        armed && !guard_fault_irq_n |=> !guard_fault_irq_n;
    endproperty
    a_latch: assert property (p_latch)
        else $error("armed fault released");
    property p_early;
        seen_kick && $rose(kick_on) && since_kick < 16'h0096
            |-> ##[1:30] !guard_fault_irq_n;
    endproperty
    a_early: assert property (p_early)
        else $error("early kick did not fault");
    c_rise: cover property ($rose(guard_fault_irq_n));
    c_latched: cover property (armed && $fell(guard_fault_irq_n));
    c_reset: cover property ($rose(sys_reset));
endmodule : wwdg_properties
`default_nettype wire

// ### tb/wwdg_bench.sv
// testbench: both watchdog ends joined, host driven over AHB-Lite
// assumes shortened supervisor counts; hreadyout is waited for
`default_nettype none
module wwdg_bench
    import wwdg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // ========================================
    // signals and instances
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel, hwrite, hreadyout, hresp;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata;
    logic supply_good, manual_reset_button_n, act_en, act_tick;
    int err_count = 0;
    int tests_run = 0;
    int cycles = 0;
    always #25 hclk = ~hclk;
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 30000) begin
            err_count++;
            wrap_up();
        end
    end
    wwdg_if lnk_if();
    wwdg_device #(.POR_HOLD(20), .DEBOUNCE(5), .ACT_TMO(100)) wwdg_device_i (
        .hclk(hclk), .hresetn(hresetn), .supply_good(supply_good),
        .manual_reset_button_n(manual_reset_button_n),
        .activity_enable(act_en), .lnk(lnk_if));
    wwdg_host wwdg_host_i (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .activity_tick(act_tick), .lnk(lnk_if));
    wwdg_properties #(.POR_HOLD(20)) wwdg_properties_i (
        .hclk(hclk), .hresetn(hresetn), .kick_sel_n(lnk_if.kick_sel_n),
        .kick_wr_n(lnk_if.kick_wr_n), .arm_sel_a_n(lnk_if.arm_sel_a_n),
        .arm_sel_b_n(lnk_if.arm_sel_b_n),
        .guard_fault_irq_n(lnk_if.guard_fault_irq_n),
        .drive_kill_n(lnk_if.drive_kill_n), .sys_reset(lnk_if.sys_reset),
        .sys_reset_n(lnk_if.sys_reset_n));
    // ========================================
    // bus and compare tasks
    task automatic ahb(input logic wr, input logic [31:0] a, d,
                       output logic [31:0] q);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        // read data taken at the edge that closes the data phase
        q = hrdata;
    endtask : ahb
    task automatic idle(input int n);
        repeat (n) @(posedge hclk);
    endtask : idle
    task automatic check_bit(input logic got, exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_bit
    // a write must leave its link pulse running when read back at once
    task automatic ctrl(input int b);
        logic [31:0] q;
        ahb(1'b1, HOST_CTRL_ADDR, 32'h1 << b, q);
        ahb(1'b0, HOST_CTRL_ADDR, 32'h0, q);
        check_bit(q[b], 1'b1);
    endtask : ctrl
    task automatic stat(input logic irq, rst, input logic chk_irq);
        logic [31:0] s;
        ahb(1'b0, HOST_STAT_ADDR, 32'h0, s);
        if (chk_irq) check_bit(s[STAT_IRQN_BIT], irq);
        if (chk_irq) check_bit(s[STAT_KILLN_BIT], irq);
        check_bit(s[STAT_RSTN_BIT], rst);
    endtask : stat
    // two good kicks bring an unarmed watchdog back to irq high
    task automatic recover();
        ctrl(CTRL_KICK_BIT);
        idle(400);
        ctrl(CTRL_KICK_BIT);
        idle(300);
    endtask : recover
    // ========================================
    // scenarios
    task automatic t_windows();
        stat(1'b0, 1'b0, 1'b0);
        idle(40);
        stat(1'b0, 1'b1, 1'b1);
        recover();
        stat(1'b1, 1'b1, 1'b1);
        idle(1400);
        stat(1'b0, 1'b1, 1'b1);
        recover();
        stat(1'b1, 1'b1, 1'b1);
        ctrl(CTRL_KICK_BIT);
        idle(30);
        ctrl(CTRL_KICK_BIT);
        idle(40);
        stat(1'b0, 1'b1, 1'b1);
    endtask : t_windows
    task automatic t_supervisor();
        logic [31:0] s;
        supply_good <= 1'b0;
        idle(10);
        stat(1'b0, 1'b0, 1'b0);
        supply_good <= 1'b1;
        idle(8);
        stat(1'b0, 1'b0, 1'b0);
        idle(40);
        manual_reset_button_n <= 1'b0;
        idle(3);
        manual_reset_button_n <= 1'b1;
        idle(10);
        stat(1'b0, 1'b1, 1'b0);
        manual_reset_button_n <= 1'b0;
        idle(20);
        stat(1'b0, 1'b0, 1'b0);
        manual_reset_button_n <= 1'b1;
        idle(12);
        stat(1'b0, 1'b0, 1'b0);
        idle(40);
        stat(1'b0, 1'b1, 1'b0);
        act_en <= 1'b1;
        repeat (20) begin
            act_tick <= 1'b1;
            idle(1);
            act_tick <= 1'b0;
            idle(9);
        end
        stat(1'b0, 1'b1, 1'b0);
        s = 32'hFFFF_FFFF;
        for (int i = 0; i < 60 && s[STAT_RSTN_BIT] !== 1'b0; i++) begin
            ahb(1'b0, HOST_STAT_ADDR, 32'h0, s);
        end
        check_bit(s[STAT_RSTN_BIT], 1'b0);
        act_en <= 1'b0;
        idle(40);
    endtask : t_supervisor
    task automatic t_armed();
        recover();
        ctrl(CTRL_ARM_BIT);
        idle(100);
        ctrl(CTRL_KICK_BIT);
        idle(300);
        stat(1'b1, 1'b1, 1'b1);
        idle(1400);
        stat(1'b0, 1'b1, 1'b1);
        recover();
        stat(1'b0, 1'b1, 1'b1);
        hresetn <= 1'b0;
        idle(16);
        hresetn <= 1'b1;
        idle(40);
        recover();
        stat(1'b1, 1'b1, 1'b1);
    endtask : t_armed
    task automatic wrap_up();
        if (err_count == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : wrap_up
    initial begin
        hsel = 1'b0;
        htrans = 2'h0;
        haddr = 32'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        supply_good = 1'b1;
        manual_reset_button_n = 1'b1;
        act_en = 1'b0;
        act_tick = 1'b0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        t_windows();
        t_supervisor();
        t_armed();
        wrap_up();
    end
endmodule : wwdg_bench
`default_nettype wire
